/* File: src/cscu_top.sv */
/*
 * Configuration and security command unit top.
 * Holds working settings, privilege handling, edit mode, signatures and
 * the scratchpad. Assumes a framing front end that presents one byte per
 * strobe with a 7-bit address, and a one-time memory read port that answers
 * in one cycle.
 */
`timescale 1ns/1ps
module cscu_top
	import cscu_pkg::*;
#(
	parameter int CFG_N = cscu_pkg::CFG_BYTES,
	parameter logic [15:0] IROM_SIG = 16'h1111, // arbitrary values
	parameter logic [15:0] DROM_SIG = 16'h2222
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// host command port
	input wire logic cmdWrite,
	input wire logic cmdRead,
	input wire logic [6:0] cmdAddr,
	input wire logic [7:0] cmdWdata,
	output logic [7:0] cmdRdata,
	output logic cmdRvalid,
	// power state from the system
	input wire cscu_pkg::cscu_power_t powerState,
	// stored one-time memory
	output logic [4:0] otpAddr,
	input wire logic [7:0] otpRdata,
	input wire logic otpValid,
	output logic otpWrite,
	output logic [7:0] otpWdata,
	// operation control
	output logic runEnable,
	output logic [7:0] alarmEnable
);
	import cscu_pkg::*;

	initial
	begin
		if (CFG_N != CFG_BYTES)
			$error("CFG_N must equal the config size");
	end

	cscu_key_if keyBus();
	cscu_state_t state;
	logic [7:0] cfgMem [CFG_N];
	logic [7:0] scratch [SCRATCH_BYTES];
	logic [7:0] block [SCRATCH_BYTES];
	logic [15:0] subCode;
	logic [15:0] result;
	logic [15:0] sigAcc;
	logic [15:0] cfgStored;
	logic [5:0] walk;
	logic [1:0] sigKind;
	logic editMode;
	logic cfgBad;
	logic subFire;
	logic subHiWrite;
	logic [15:0] next_subCode;
	logic [7:0] alarmReg;
	logic [7:0] next_rdata;
	logic clearAll;
	logic subAllowed;
	logic [4:0] blockIdx;

	// ----------------------------------------
	// privilege keeper
	// ----------------------------------------
	cscu_key_check u_keys (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.clearLevel(clearAll),
		.keys(keyBus.checker_end)
	);

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	// a subcommand fires when its high byte lands, low byte latched first
	assign clearAll = (powerState == CSCU_PWR_OFF);
	assign subHiWrite = cmdWrite && cmdAddr == CMD_SUB_HI && state == CSCU_S_RUN;
	assign next_subCode = {cmdWdata, subCode[7:0]};
	assign subFire = subHiWrite;
	assign blockIdx = cmdAddr[4:0] - CMD_BLOCK_BASE[4:0];
	assign keyBus.keyStrobe = subFire;
	assign keyBus.keyWord = next_subCode;

	// permission per subcommand against the current level
	always_comb
	begin
		subAllowed = 1'b0;
		if (next_subCode == SUB_IROM_SIG || next_subCode == SUB_DROM_SIG
			|| next_subCode == SUB_CFG_SIG || next_subCode == SUB_SCRATCH
			|| next_subCode == SUB_LOCK)
			subAllowed = 1'b1;
		else if (next_subCode >= SUB_DATAMEM_LO && next_subCode <= SUB_DATAMEM_HI)
			subAllowed = keyBus.level != CSCU_LOCKED;
		else if (next_subCode == SUB_EDIT_ENTER)
			subAllowed = keyBus.level == CSCU_FULL && !editMode;
		else if (next_subCode == SUB_EDIT_EXIT)
			subAllowed = editMode;
		else if (next_subCode == SUB_OTP_WRITE)
			subAllowed = keyBus.level == CSCU_FULL && editMode;
	end

	// ----------------------------------------
	// subcommand register and block buffer
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
			subCode <= 16'h0000;
		else if (cmdWrite && cmdAddr == CMD_SUB_LO)
			subCode <= {subCode[15:8], cmdWdata};
		else if (subHiWrite)
			subCode <= next_subCode;

	// block transfer window shared by scratchpad and data memory
	always_ff @(posedge core_clk)
		if (cmdWrite && cmdAddr >= CMD_BLOCK_BASE && cmdAddr <= CMD_BLOCK_LAST)
			block[blockIdx] <= cmdWdata;

	// ----------------------------------------
	// engine: load, run, sign, commit, off
	// ----------------------------------------
	// one byte per cycle keeps a single rotate-xor signature step instead of a wide tree
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
		begin
			state <= CSCU_S_LOAD;
			walk <= 6'h00;
			sigAcc <= 16'h0000;
			sigKind <= 2'b00;
			cfgStored <= 16'h0000;
			result <= 16'h0000;
			editMode <= 1'b0;
			cfgBad <= 1'b0;
		end
		else if (clearAll)
		begin
			state <= CSCU_S_OFF;
			editMode <= 1'b0;
			walk <= 6'h00;
		end
		else
		begin
			unique case (state)
				CSCU_S_OFF:
				begin
					state <= CSCU_S_LOAD; // power back: reload
					walk <= 6'h00;
				end
				CSCU_S_LOAD:
					if (otpValid)
					begin
						if (walk == 6'(CFG_N - 1))
						begin
							state <= CSCU_S_RUN;
							cfgStored <= cscu_sig_step(sigAcc, otpRdata);
						end
						sigAcc <= walk == 6'h00 ? cscu_sig_step(16'h0000, otpRdata)
							: cscu_sig_step(sigAcc, otpRdata);
						walk <= walk + 6'h01;
					end
				CSCU_S_RUN:
					if (subFire && subAllowed)
					begin
						if (next_subCode == SUB_IROM_SIG)
							result <= IROM_SIG;
						else if (next_subCode == SUB_DROM_SIG)
							result <= DROM_SIG;
						else if (next_subCode == SUB_CFG_SIG)
						begin
							state <= CSCU_S_SIGN;
							walk <= 6'(CAL_BYTES);
							sigAcc <= 16'h0000;
						end
						else if (next_subCode == SUB_EDIT_ENTER)
							editMode <= 1'b1;
						else if (next_subCode == SUB_EDIT_EXIT)
							editMode <= 1'b0;
						else if (next_subCode == SUB_OTP_WRITE)
						begin
							state <= CSCU_S_OTP;
							walk <= 6'h00;
						end
					end
				CSCU_S_SIGN:
				begin
					// calibration bytes at the bottom are skipped
					sigAcc <= cscu_sig_step(sigAcc, cfgMem[walk[4:0]]);
					walk <= walk + 6'h01;
					if (walk == 6'(CFG_N - 1))
					begin
						state <= CSCU_S_RUN;
						result <= cscu_sig_step(sigAcc, cfgMem[walk[4:0]]);
						cfgBad <= cscu_sig_step(sigAcc, cfgMem[walk[4:0]]) != cfgStored;
					end
				end
				CSCU_S_OTP:
				begin
					walk <= walk + 6'h01;
					if (walk == 6'(SCRATCH_BYTES - 1))
						state <= CSCU_S_RUN;
				end
				default:
					state <= CSCU_S_LOAD;
			endcase
		end

	// ----------------------------------------
	// working settings and scratchpad
	// ----------------------------------------
	// no reset: contents simply stay through low power modes
	always_ff @(posedge core_clk)
		if (state == CSCU_S_OFF)
		begin
			for (int i = 0; i < CFG_N; i++)
				cfgMem[i] <= 8'h00;
		end
		else if (state == CSCU_S_LOAD && otpValid)
			cfgMem[walk[4:0]] <= otpRdata;
		else if (subFire && subAllowed && state == CSCU_S_RUN
			&& next_subCode >= SUB_DATAMEM_LO && next_subCode <= SUB_DATAMEM_HI)
			cfgMem[next_subCode[4:0]] <= block[0];

	always_ff @(posedge core_clk)
		if (state == CSCU_S_OFF)
		begin
			for (int i = 0; i < SCRATCH_BYTES; i++)
				scratch[i] <= 8'h00;
		end
		else if (subFire && state == CSCU_S_RUN && next_subCode == SUB_SCRATCH
			&& keyBus.level == CSCU_FULL)
		begin
			for (int i = 0; i < SCRATCH_BYTES; i++)
				scratch[i] <= block[i];
		end

	// selected setting writable at any level, outside edit mode too
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
			alarmReg <= ALARM_EN_RESET;
		else if (clearAll)
			alarmReg <= ALARM_EN_RESET;
		else if (cmdWrite && cmdAddr == CMD_ALARM_EN && state == CSCU_S_RUN)
			alarmReg <= cmdWdata;

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always_comb
	begin
		next_rdata = 8'h00;
		if (cmdAddr == CMD_STATUS)
			next_rdata = {3'b000, state == CSCU_S_OTP, cfgBad, editMode, keyBus.level};
		else if (cmdAddr == CMD_RESULT_LO)
			next_rdata = result[7:0];
		else if (cmdAddr == CMD_RESULT_HI)
			next_rdata = result[15:8];
		else if (cmdAddr == CMD_ALARM_EN)
			next_rdata = alarmReg;
		else if (cmdAddr >= CMD_BLOCK_BASE && cmdAddr <= CMD_BLOCK_LAST)
			next_rdata = subCode == SUB_SCRATCH ? scratch[blockIdx]
				: (keyBus.level != CSCU_LOCKED ? cfgMem[blockIdx] : 8'h00);
	end

	// registered answer one cycle after the read strobe
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
		begin
			cmdRdata <= 8'h00;
			cmdRvalid <= 1'b0;
		end
		else
		begin
			cmdRvalid <= cmdRead;
			if (cmdRead)
				cmdRdata <= next_rdata;
		end

	// ----------------------------------------
	// outputs toward memory and operation
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
		begin
			otpAddr <= 5'h00;
			otpWrite <= 1'b0;
			otpWdata <= 8'h00;
			runEnable <= 1'b0;
			alarmEnable <= ALARM_EN_RESET;
		end
		else
		begin
			otpAddr <= walk[4:0];
			otpWrite <= state == CSCU_S_OTP;
			otpWdata <= scratch[walk[4:0]];
			runEnable <= state == CSCU_S_RUN && !editMode;
			alarmEnable <= alarmReg;
		end

endmodule

/* File: src/cscu_pkg.sv */
/*
 * Shared constants and types for the config/security command unit.
 * Assumes a byte-wide command port in front of it that has already framed
 * host transactions into address, data and strobes.
 */
package cscu_pkg;

	// ----------------------------------------
	// direct command addresses
	// ----------------------------------------
	localparam logic [6:0] CMD_STATUS = 7'h00;
	localparam logic [6:0] CMD_SUB_LO = 7'h3E;
	localparam logic [6:0] CMD_SUB_HI = 7'h3F;
	localparam logic [6:0] CMD_BLOCK_BASE = 7'h40;
	localparam logic [6:0] CMD_BLOCK_LAST = 7'h5F;
	localparam logic [6:0] CMD_RESULT_LO = 7'h60;
	localparam logic [6:0] CMD_RESULT_HI = 7'h61;
	localparam logic [6:0] CMD_ALARM_EN = 7'h66;

	// ----------------------------------------
	// subcommand codes
	// ----------------------------------------
	localparam logic [15:0] SUB_LOCK = 16'h0030;
	localparam logic [15:0] SUB_IROM_SIG = 16'h0009;
	localparam logic [15:0] SUB_DROM_SIG = 16'h000A;
	localparam logic [15:0] SUB_CFG_SIG = 16'h000B;
	localparam logic [15:0] SUB_EDIT_ENTER = 16'h0090;
	localparam logic [15:0] SUB_EDIT_EXIT = 16'h0092;
	localparam logic [15:0] SUB_OTP_WRITE = 16'h00A0;
	localparam logic [15:0] SUB_SCRATCH = 16'h0070;
	localparam logic [15:0] SUB_DATAMEM_LO = 16'h9000;
	localparam logic [15:0] SUB_DATAMEM_HI = 16'h901F;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int ST_LEVEL_LSB = 0;
	localparam int ST_EDIT_BIT = 2;
	localparam int ST_CFG_BAD_BIT = 3;
	localparam int ST_OTP_BUSY_BIT = 4;
	localparam logic [7:0] ALARM_EN_RESET = 8'h00;
	localparam int SCRATCH_BYTES = 32;
	localparam int CFG_BYTES = 32;
	localparam int CAL_BYTES = 4;

	// ----------------------------------------
	// privilege levels, gray along lock -> unlock -> full
	// ----------------------------------------
	typedef enum logic [1:0] {
		CSCU_LOCKED = 2'b00,
		CSCU_UNLOCKED = 2'b01,
		CSCU_FULL = 2'b11
	} cscu_level_t;

	// power states reported by the system
	typedef enum logic [1:0] {
		CSCU_PWR_ACTIVE = 2'b00,
		CSCU_PWR_LOW = 2'b01,
		CSCU_PWR_DEEP = 2'b11,
		CSCU_PWR_OFF = 2'b10
	} cscu_power_t;

	// loader/engine states
	typedef enum logic [2:0] {
		CSCU_S_LOAD = 3'b000,
		CSCU_S_RUN = 3'b001,
		CSCU_S_SIGN = 3'b011,
		CSCU_S_OTP = 3'b010,
		CSCU_S_OFF = 3'b110
	} cscu_state_t;

	// signature step: 16-bit rotate-xor, shared by the stored and live config signatures
	function automatic logic [15:0] cscu_sig_step(input logic [15:0] acc, input logic [7:0] b);
		cscu_sig_step = {acc[14:0], acc[15]} ^ {8'h00, b} ^ 16'hA001;
	endfunction

endpackage

/* File: src/cscu_key_if.sv */
/*
 * Carrier between the command decoder and the key checker.
 * Assumes both ends share core_clk.
 */
`timescale 1ns/1ps
interface cscu_key_if;
	logic keyStrobe;
	logic [15:0] keyWord;
	logic [1:0] level;
	modport decoder (output keyStrobe, output keyWord, input level);
	modport checker_end (input keyStrobe, input keyWord, output level);
endinterface

/* File: src/cscu_key_check.sv */
/*
 * Privilege level keeper: tracks pairs of key words and moves the level
 * only on the exact pair for that step.
 * Assumes key words arrive one per strobe from the decoder.
 */
`timescale 1ns/1ps
module cscu_key_check
	import cscu_pkg::*;
#(
	parameter logic [15:0] UNLOCK_KEY1 = 16'h1234, // arbitrary values
	parameter logic [15:0] UNLOCK_KEY2 = 16'h5678,
	parameter logic [15:0] FULL_KEY1 = 16'h9ABC,
	parameter logic [15:0] FULL_KEY2 = 16'hDEF0
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// clear to locked on power-off
	input wire logic clearLevel,
	// decoder side
	cscu_key_if.checker_end keys
);
	cscu_level_t level;
	logic [15:0] lastKey;
	logic haveFirst;

	assign keys.level = level;

	// ----------------------------------------
	// key pair tracking
	// ----------------------------------------
	// a wrong second word just restarts the pair, so a stray word cannot leave a half key armed
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
		begin
			level <= CSCU_LOCKED;
			lastKey <= 16'h0000;
			haveFirst <= 1'b0;
		end
		else if (clearLevel)
		begin
			level <= CSCU_LOCKED;
			haveFirst <= 1'b0;
		end
		else if (keys.keyStrobe)
		begin
			lastKey <= keys.keyWord;
			haveFirst <= 1'b1;
			if (haveFirst && level == CSCU_LOCKED && lastKey == UNLOCK_KEY1
				&& keys.keyWord == UNLOCK_KEY2)
			begin
				level <= CSCU_UNLOCKED;
				haveFirst <= 1'b0;
			end
			else if (haveFirst && level == CSCU_UNLOCKED && lastKey == FULL_KEY1
				&& keys.keyWord == FULL_KEY2)
			begin
				level <= CSCU_FULL;
				haveFirst <= 1'b0;
			end
		end
endmodule

/* File: tb/cscu_top_checker.sv */
/*
 * Port checker for the config/security command unit.
 * Bound to cscu_top; sees only its ports, one clock domain.
 */
`timescale 1ns/1ps
module cscu_top_checker
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// host command port
	input wire logic cmdWrite,
	input wire logic cmdRead,
	input wire logic [6:0] cmdAddr,
	input wire logic [7:0] cmdWdata,
	input wire logic [7:0] cmdRdata,
	input wire logic cmdRvalid,
	// power, one-time memory, control
	input wire cscu_pkg::cscu_power_t powerState,
	input wire logic [4:0] otpAddr,
	input wire logic otpWrite,
	input wire logic runEnable,
	input wire logic [7:0] alarmEnable
);
	import cscu_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	logic [5:0] wrLen;

	// ----------------------------------------
	// helper: length of the running commit burst
	// ----------------------------------------
	// a counter, since 32 cycles is past what a repetition may say
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			wrLen <= 6'h00;
		else
			wrLen <= otpWrite ? wrLen + 6'h01 : 6'h00;
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_rvalid_cause;
		cmdRvalid |-> $past(cmdRead);
	endproperty
	a_rvalid_cause: assert property (p_rvalid_cause)
		else $error("read answer without a read");
	property p_rvalid_answer;
		cmdRead && runEnable && powerState != CSCU_PWR_OFF |=> cmdRvalid;
	endproperty
	a_rvalid_answer: assert property (p_rvalid_answer)
		else $error("read not answered next cycle");
	property p_off_clear;
		// outputs are registered copies of state, so the clear shows two edges later
		powerState == CSCU_PWR_OFF |-> ##2 (alarmEnable == 8'h00 && !runEnable);
	endproperty
	a_off_clear: assert property (p_off_clear)
		else $error("power off did not clear");
	property p_alarm_hold;
		runEnable && powerState != CSCU_PWR_OFF && !(cmdWrite && cmdAddr == CMD_ALARM_EN)
			&& !$past(cmdWrite && cmdAddr == CMD_ALARM_EN) |=> $stable(alarmEnable);
	endproperty
	a_alarm_hold: assert property (p_alarm_hold)
		else $error("setting changed without a write");
	property p_alarm_write;
		cmdWrite && cmdAddr == CMD_ALARM_EN && runEnable && powerState != CSCU_PWR_OFF
			|=> ##1 alarmEnable == $past(cmdWdata, 2);
	endproperty
	a_alarm_write: assert property (p_alarm_write)
		else $error("selected setting not written");
	property p_burst_len;
		$fell(otpWrite) |-> wrLen == 6'h20;
	endproperty
	a_burst_len: assert property (p_burst_len)
		else $error("commit burst not 32 cycles");
	property p_burst_start;
		$rose(otpWrite) |-> otpAddr == 5'h00;
	endproperty
	a_burst_start: assert property (p_burst_start)
		else $error("commit does not start at 0");
	property p_burst_step;
		otpWrite && $past(otpWrite) |-> otpAddr == $past(otpAddr) + 5'h01;
	endproperty
	a_burst_step: assert property (p_burst_step)
		else $error("commit address skipped");
endmodule

bind cscu_top cscu_top_checker u_chk (.core_clk(core_clk), .rst_b(rst_b),
	.cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata),
	.cmdRdata(cmdRdata), .cmdRvalid(cmdRvalid), .powerState(powerState),
	.otpAddr(otpAddr), .otpWrite(otpWrite), .runEnable(runEnable),
	.alarmEnable(alarmEnable));

/* File: tb/cscu_host_model.sv */
/*
 * Host model: drives command port cycles for the bench.
 * Assumes the unit samples requests on core_clk rising edges.
 */
`timescale 1ns/1ps
module cscu_host_model
(
	// clock
	input wire logic core_clk,
	// command port
	output logic cmdWrite,
	output logic cmdRead,
	output logic [6:0] cmdAddr,
	output logic [7:0] cmdWdata
);
	import cscu_pkg::*;

	// idle port at time zero
	initial
	begin
		cmdWrite = 1'b0;
		cmdRead = 1'b0;
		cmdAddr = 7'h00;
		cmdWdata = 8'h00;
	end

	// one request; released lines flip so stale values are never read as good
	task automatic cyc(input logic w, input logic [6:0] ad, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		cmdWrite = w;
		cmdRead = ~w;
		cmdAddr = ad;
		cmdWdata = d;
		@(posedge core_clk);
		#1;
		cmdWrite = 1'b0;
		cmdRead = 1'b0;
		cmdAddr = ~ad;
		cmdWdata = ~d;
	endtask

	task automatic wr(input logic [6:0] ad, input logic [7:0] d);
		cyc(1'b1, ad, d);
	endtask

	task automatic rd(input logic [6:0] ad);
		cyc(1'b0, ad, 8'h00);
	endtask

	// subcommand word: low byte first, fires on the high byte
	task automatic sub(input logic [15:0] code);
		wr(CMD_SUB_LO, code[7:0]);
		wr(CMD_SUB_HI, code[15:8]);
	endtask
endmodule

/* File: tb/tb.sv */
/*
 * Self-checking bench for cscu_top.
 * Assumes the host model drives the command port; the bench feeds OTP.
 */
`timescale 1ns/1ps
module tb;
	import cscu_pkg::*;
	localparam logic [15:0] ISIG = 16'h3C5A; // arbitrary value
	localparam logic [15:0] DSIG = 16'hA55A; // arbitrary value
	logic core_clk, rst_b, cmdWrite, cmdRead, cmdRvalid, otpValid, otpWrite, runEnable;
	logic [6:0] cmdAddr;
	logic [7:0] cmdWdata, cmdRdata, otpRdata, otpWdata, alarmEnable, a;
	logic [7:0] sb [32];
	logic [4:0] otpAddr;
	cscu_power_t powerState;
	int mismatches, compares, n;
	logic [7:0] expQ [$];

	cscu_top #(.IROM_SIG(ISIG), .DROM_SIG(DSIG)) dut (.core_clk(core_clk), .rst_b(rst_b),
		.cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata),
		.cmdRdata(cmdRdata), .cmdRvalid(cmdRvalid), .powerState(powerState),
		.otpAddr(otpAddr), .otpRdata(otpRdata), .otpValid(otpValid), .otpWrite(otpWrite),
		.otpWdata(otpWdata), .runEnable(runEnable), .alarmEnable(alarmEnable));
	cscu_host_model host (.core_clk(core_clk), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
		.cmdAddr(cmdAddr), .cmdWdata(cmdWdata));

	// 100 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic ticks(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask

	// note the answer first, then ask
	task automatic rd(input logic [6:0] ad, input logic [7:0] e);
		expQ.push_back(e);
		host.rd(ad);
	endtask

	// power-up load: 32 random bytes, then wait for run
	task automatic load_otp;
		for (int i = 0; i < 32; i++)
		begin
			otpValid = 1'b1;
			otpRdata = 8'($urandom);
			ticks(1);
		end
		otpValid = 1'b0;
		otpRdata = ~otpRdata;
		n = 0;
		while (runEnable !== 1'b1 && n < 50)
		begin
			ticks(1);
			n++;
		end
	endtask

	task give_verdict;
		$display("counts: %0d compares, %0d mismatches", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// read answers are matched against the oldest note
	always @(posedge core_clk)
	begin
		if (cmdRvalid === 1'b1)
		begin
			if (expQ.size() == 0)
				chk(cmdRdata, ~cmdRdata, "unexpected read");
			else
				chk(cmdRdata, expQ.pop_front(), "read data");
		end
	end

	// watchdog, far beyond the few hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		$display("wrong value at %0t: watchdog expired", $time);
		give_verdict;
	end

	initial
	begin
		rst_b = 1'b0;
		otpValid = 1'b0;
		otpRdata = 8'h00;
		powerState = CSCU_PWR_ACTIVE;
		mismatches = 0;
		compares = 0;
		void'($urandom(16));
		ticks(16);
		rst_b = 1'b1;
		load_otp;
		chk({7'h00, runEnable}, 8'h01, "run after load");
		rd(CMD_STATUS, 8'h00);
		$display("test load done");
		a = 8'($urandom);
		host.wr(CMD_ALARM_EN, a);
		ticks(1);
		chk(alarmEnable, a, "locked setting");
		host.sub(SUB_EDIT_ENTER);
		host.sub(16'h1234);
		host.sub(16'h9ABC);
		host.sub(16'h5678);
		chk({7'h00, runEnable}, 8'h01, "edit refused");
		rd(CMD_STATUS, 8'h00);
		host.sub(16'h1234);
		host.sub(16'h5678);
		rd(CMD_STATUS, 8'h01);
		host.sub(SUB_EDIT_ENTER);
		rd(CMD_STATUS, 8'h01);
		host.sub(16'h9ABC);
		host.sub(16'hDEF0);
		rd(CMD_STATUS, 8'h03);
		$display("test keys done");
		for (int i = 0; i < 32; i++)
		begin
			sb[i] = 8'($urandom);
			host.wr(CMD_BLOCK_BASE + 7'(i), sb[i]);
		end
		host.sub(SUB_SCRATCH);
		for (int i = 0; i < 32; i++)
			rd(CMD_BLOCK_BASE + 7'(i), sb[i]);
		host.sub(SUB_IROM_SIG);
		rd(CMD_RESULT_LO, ISIG[7:0]);
		rd(CMD_RESULT_HI, ISIG[15:8]);
		host.sub(SUB_DROM_SIG);
		rd(CMD_RESULT_LO, DSIG[7:0]);
		rd(CMD_RESULT_HI, DSIG[15:8]);
		$display("test scratch and signatures done");
		host.sub(SUB_EDIT_ENTER);
		ticks(1);
		chk({7'h00, runEnable}, 8'h00, "edit halts");
		rd(CMD_STATUS, 8'h07);
		a = ~a;
		host.wr(CMD_ALARM_EN, a);
		host.sub(SUB_OTP_WRITE);
		n = 0;
		while (otpWrite !== 1'b1 && n < 10)
		begin
			ticks(1);
			n++;
		end
		n = 0;
		while (otpWrite === 1'b1 && n < 40)
		begin
			ticks(1);
			n++;
		end
		chk(8'(n), 8'h20, "commit length");
		host.sub(SUB_EDIT_EXIT);
		ticks(1);
		chk({7'h00, runEnable}, 8'h01, "resume");
		chk(alarmEnable, a, "new setting");
		$display("test edit done");
		powerState = CSCU_PWR_LOW;
		ticks(5);
		powerState = CSCU_PWR_DEEP;
		ticks(5);
		powerState = CSCU_PWR_ACTIVE;
		chk(alarmEnable, a, "kept in low power");
		rd(CMD_STATUS, 8'h03);
		powerState = CSCU_PWR_OFF;
		ticks(3);
		chk(alarmEnable, 8'h00, "off clears");
		powerState = CSCU_PWR_ACTIVE;
		// one edge to leave the off state before the first byte is offered
		ticks(1);
		load_otp;
		rd(CMD_STATUS, 8'h00);
		host.wr(CMD_ALARM_EN, a);
		ticks(1);
		chk(alarmEnable, a, "rewritten setting");
		$display("test power done");
		ticks(3);
		chk(8'(expQ.size()), 8'h00, "missing reads");
		give_verdict;
	end
endmodule
